// ==== src/jhs_sequencer.v ====
// homing sequencer of an electric gripper drive
//
// Contract
// (R1) mode 10: outward slow to stop, position 0
// (R2) mode 14: inward slow, position max stroke
// (R3) internal homing accepted motor on or off
// (R4) controller sends no homing while gripped
// (R5) mode 3 with command 1 energizes motor
// (R6) external homing parameters taken with command 1
// (R7) mode 16: outward to stop, load outer target
// (R8) controller keeps outer target at least 75
// (R9) mode 17: inward to stop, load inner target
// (R10) controller keeps inner target within max
// (R11) motor off after external homing; re-enable
// (R12) fault word zero once operation restarts
// (R13) controller prefers ten percent external homing
// (R14) controller avoids 16 and 17 on safety jaws
// (R15) variants may reference slightly above zero
// (R16) ack bit 12 set when data taken
// (R17) bit 0 shows valid reference
// (R18) bit 1 follows motor state
// (R19) set referenced; reject homing when gripped
`timescale 1ns/100ps
`include "jhs_regs.vh"
module jhs_sequencer (
    // clock and reset
    input wire clk_sys_i,
    input wire resetn_i,
    // cyclic process data from the controller
    input wire [7:0] operating_selector_i,
    input wire [15:0] command_word_i,
    input wire [7:0] recipe_index_i,
    input wire [15:0] window_tolerance_i,
    input wire [7:0] travel_speed_percent_i,
    input wire [15:0] outer_target_i,
    input wire [15:0] inner_target_i,
    // gripper state from the profile logic
    input wire gripped_i,
    // raw position from the measuring system pin bus
    input wire [15:0] raw_position_i,
    // motor drive
    output reg motor_enable_o,
    output reg drive_run_o,
    output reg drive_outward_o,
    output reg [7:0] drive_speed_o,
    // cyclic process data to the controller
    output reg [15:0] status_word_o,
    output reg [15:0] fault_code_word_o,
    output reg [15:0] measured_jaw_position_o,
    output reg [7:0] recipe_index_o,
    output reg [15:0] window_tolerance_o
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_DONE = 3'b100;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [15:0] raw_s1_ff;
    reg [15:0] raw_s2_ff;
    reg [15:0] offset_ff;
    reg [15:0] nxt_offset;
    reg [15:0] ref_value_ff;
    reg [15:0] nxt_ref_value;
    reg [7:0] mode_ff;
    reg [7:0] nxt_mode;
    reg cmd_was_xfer_ff;
    reg ack_ff;
    reg nxt_ack;
    reg referenced_ff;
    reg nxt_referenced;
    reg motor_ff;
    reg nxt_motor;
    reg complete_ff;
    reg nxt_complete;
    reg [15:0] fault_ff;
    reg [15:0] nxt_fault;
    reg run_ff;
    reg nxt_run;
    reg outward_ff;
    reg nxt_outward;
    reg [7:0] speed_ff;
    reg [7:0] nxt_speed;
    reg [7:0] recipe_ff;
    reg [15:0] tol_ff;
    wire stalled;
    wire take;
    wire [15:0] measured;

    // a new transfer is the first cycle that command word holds 1
    assign take = (command_word_i == `JHS_CMD_TRANSFER) && !cmd_was_xfer_ff;
    assign measured = raw_s2_ff - offset_ff;

    function is_homing;
        input [7:0] sel;
        begin
            is_homing = (sel == `JHS_SEL_HOME_OUT) || (sel == `JHS_SEL_HOME_IN) ||
                        (sel == `JHS_SEL_EXT_OUT) || (sel == `JHS_SEL_EXT_IN);
        end
    endfunction

    jhs_stall_detect u_stall (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .arm_i(run_ff),
        .position_i(raw_s2_ff),
        .stalled_o(stalled)
    );

    always @* begin
        nxt_state = state_ff;
        nxt_offset = offset_ff;
        nxt_ref_value = ref_value_ff;
        nxt_mode = mode_ff;
        nxt_ack = ack_ff;
        nxt_referenced = referenced_ff;
        nxt_motor = motor_ff;
        nxt_complete = complete_ff;
        nxt_fault = fault_ff;
        nxt_run = run_ff;
        nxt_outward = outward_ff;
        nxt_speed = speed_ff;
        // ack stands until the controller drops the transfer value
        if (command_word_i != `JHS_CMD_TRANSFER) begin
            nxt_ack = 1'b0;
        end
        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_ack = 1'b1; // R16
                    nxt_mode = operating_selector_i;
                    if (operating_selector_i == `JHS_SEL_MOTOR_ON) begin
                        nxt_motor = 1'b1; // R5 R11
                        nxt_fault = `JHS_FAULT_NONE; // R12
                    end else if (is_homing(operating_selector_i) && gripped_i) begin
                        nxt_fault = `JHS_FAULT_GRIPPED; // R4 R19
                    end else if (is_homing(operating_selector_i)) begin
                        nxt_motor = 1'b1; // R3
                        nxt_run = 1'b1;
                        nxt_complete = 1'b0;
                        nxt_referenced = 1'b0;
                        nxt_fault = `JHS_FAULT_NONE;
                        nxt_state = ST_RUN;
                        case (operating_selector_i)
                            `JHS_SEL_HOME_OUT: begin
                                nxt_outward = 1'b1; // R1
                                nxt_speed = `JHS_LOW_SPEED;
                                nxt_ref_value = `JHS_POS_ZERO; // R15
                            end
                            `JHS_SEL_HOME_IN: begin
                                nxt_outward = 1'b0; // R2
                                nxt_speed = `JHS_LOW_SPEED;
                                nxt_ref_value = `JHS_MAX_STROKE;
                            end
                            `JHS_SEL_EXT_OUT: begin
                                nxt_outward = 1'b1; // R7 R6
                                nxt_speed = travel_speed_percent_i; // R13
                                nxt_ref_value = outer_target_i; // R8
                            end
                            default: begin
                                nxt_outward = 1'b0; // R9 R6
                                nxt_speed = travel_speed_percent_i;
                                nxt_ref_value = inner_target_i; // R10
                            end
                        endcase
                    end
                end
            end
            ST_RUN: begin
                // resistance or end stop halts the jaws and fixes the reference
                if (stalled) begin
                    nxt_run = 1'b0;
                    nxt_speed = `JHS_SPEED_ZERO;
                    nxt_offset = raw_s2_ff - ref_value_ff; // R1 R2 R7 R9
                    nxt_referenced = 1'b1; // R17 R19
                    nxt_complete = 1'b1;
                    nxt_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (mode_ff == `JHS_SEL_EXT_OUT || mode_ff == `JHS_SEL_EXT_IN) begin
                    nxt_motor = 1'b0; // R11 R18
                end
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_run = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff <= ST_IDLE;
            raw_s1_ff <= 16'h0000;
            raw_s2_ff <= 16'h0000;
            offset_ff <= 16'h0000;
            ref_value_ff <= 16'h0000;
            mode_ff <= 8'h00;
            cmd_was_xfer_ff <= 1'b0;
            ack_ff <= 1'b0;
            referenced_ff <= 1'b0;
            motor_ff <= 1'b0;
            complete_ff <= 1'b0;
            fault_ff <= `JHS_FAULT_NONE;
            run_ff <= 1'b0;
            outward_ff <= 1'b0;
            speed_ff <= `JHS_SPEED_ZERO;
            recipe_ff <= 8'h00;
            tol_ff <= 16'h0000;
            motor_enable_o <= 1'b0;
            drive_run_o <= 1'b0;
            drive_outward_o <= 1'b0;
            drive_speed_o <= `JHS_SPEED_ZERO;
            status_word_o <= 16'h0000;
            fault_code_word_o <= `JHS_FAULT_NONE;
            measured_jaw_position_o <= 16'h0000;
            recipe_index_o <= 8'h00;
            window_tolerance_o <= 16'h0000;
        end else begin
            raw_s1_ff <= raw_position_i;
            raw_s2_ff <= raw_s1_ff;
            state_ff <= nxt_state;
            offset_ff <= nxt_offset;
            ref_value_ff <= nxt_ref_value;
            mode_ff <= nxt_mode;
            cmd_was_xfer_ff <= (command_word_i == `JHS_CMD_TRANSFER);
            ack_ff <= nxt_ack;
            referenced_ff <= nxt_referenced;
            motor_ff <= nxt_motor;
            complete_ff <= nxt_complete;
            fault_ff <= nxt_fault;
            run_ff <= nxt_run;
            outward_ff <= nxt_outward;
            speed_ff <= nxt_speed;
            // transfers during a run or its done cycle are ignored
            if (take && state_ff == ST_IDLE) begin
                recipe_ff <= recipe_index_i; // R6
                tol_ff <= window_tolerance_i;
            end
            motor_enable_o <= nxt_motor;
            drive_run_o <= nxt_run;
            drive_outward_o <= nxt_outward;
            drive_speed_o <= nxt_speed;
            fault_code_word_o <= nxt_fault;
            measured_jaw_position_o <= measured;
            recipe_index_o <= recipe_ff;
            window_tolerance_o <= tol_ff;
            status_word_o <= 16'h0000;
            status_word_o[`JHS_ST_REFERENCED] <= nxt_referenced; // R17
            status_word_o[`JHS_ST_MOTOR] <= nxt_motor; // R18
            status_word_o[`JHS_ST_MOTION] <= nxt_run;
            status_word_o[`JHS_ST_COMPLETE] <= nxt_complete;
            status_word_o[`JHS_ST_ACK] <= nxt_ack; // R16
            status_word_o[`JHS_ST_ERROR] <= (nxt_fault != `JHS_FAULT_NONE);
        end
    end
endmodule // jhs_sequencer

// ==== src/jhs_regs.vh ====
// constants of the jaw homing sequencer
`ifndef JHS_REGS_VH
`define JHS_REGS_VH
// operating selector codes
`define JHS_SEL_MOTOR_ON 8'h03
`define JHS_SEL_HOME_OUT 8'h0A
`define JHS_SEL_HOME_IN 8'h0E
`define JHS_SEL_EXT_OUT 8'h10
`define JHS_SEL_EXT_IN 8'h11
// command word value that transfers the parameters
`define JHS_CMD_TRANSFER 16'h0001
`define JHS_CMD_IDLE 16'h0000
// status word bit positions
`define JHS_ST_REFERENCED 0
`define JHS_ST_MOTOR 1
`define JHS_ST_MOTION 2
`define JHS_ST_COMPLETE 3
`define JHS_ST_ACK 12
`define JHS_ST_ERROR 15
// fault codes
`define JHS_FAULT_NONE 16'h0000
`define JHS_FAULT_GRIPPED 16'h0001
// positions in 0.01 mm
`define JHS_POS_ZERO 16'h0000
`define JHS_MAX_STROKE 16'h0FA0
// speed in percent for internal end stop runs
`define JHS_LOW_SPEED 8'h0A
`define JHS_SPEED_ZERO 8'h00
// standstill time that counts as resistance
`define JHS_CLK_MHZ 250
`define JHS_STALL_NS 1000
`define JHS_STALL_CYCLES ((`JHS_STALL_NS * `JHS_CLK_MHZ) / 1000)
`define JHS_STALL_W 12
`endif

// ==== src/jhs_stall_detect.v ====
// standstill detector: flags resistance when the position stops changing
`timescale 1ns/100ps
`include "jhs_regs.vh"
module jhs_stall_detect (
    // clock and reset
    input wire clk_sys_i,
    input wire resetn_i,
    // control
    input wire arm_i,
    input wire [15:0] position_i,
    // result
    output reg stalled_o
);
    // full-width count first, then cut to the counter width on purpose
    localparam [31:0] STALL_LAST_FULL = `JHS_STALL_CYCLES - 1;
    localparam [`JHS_STALL_W-1:0] STALL_LAST = STALL_LAST_FULL[`JHS_STALL_W-1:0];
    reg [15:0] last_pos_ff;
    reg [`JHS_STALL_W-1:0] still_cnt_ff;
    always @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            last_pos_ff <= 16'h0000;
            still_cnt_ff <= {`JHS_STALL_W{1'b0}};
            stalled_o <= 1'b0;
        end else begin
            last_pos_ff <= position_i;
            if (!arm_i || position_i != last_pos_ff) begin
                still_cnt_ff <= {`JHS_STALL_W{1'b0}};
                stalled_o <= 1'b0;
            end else if (still_cnt_ff == STALL_LAST) begin
                stalled_o <= 1'b1;
            end else begin
                still_cnt_ff <= still_cnt_ff + 1'b1;
            end
        end
    end
endmodule // jhs_stall_detect

// ==== tb/jhs_seq_properties.sv ====
// assertion checker on the ports of the jaw homing sequencer
`timescale 1ns/100ps
`include "jhs_regs.vh"
module jhs_seq_properties (
    // clock and reset
    input wire clk_sys_i, input wire resetn_i,
    // controller side
    input wire [7:0] operating_selector_i, input wire [15:0] command_word_i,
    input wire [7:0] travel_speed_percent_i, input wire gripped_i,
    // drive and status
    input wire motor_enable_o, input wire drive_run_o, input wire drive_outward_o,
    input wire [7:0] drive_speed_o, input wire [15:0] status_word_o, input wire [15:0] fault_code_word_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // a transfer taken while the sequencer is idle
    sequence s_take(logic [7:0] code);
        command_word_i == `JHS_CMD_TRANSFER && $past(command_word_i) != `JHS_CMD_TRANSFER
            && operating_selector_i == code && !drive_run_o && !$past(drive_run_o) && !$past(drive_run_o, 2);
    endsequence
    sequence s_home(logic [7:0] code);
        s_take(code) ##0 !gripped_i;
    endsequence
    AST_ACK: assert property (s_take(operating_selector_i) |=> status_word_o[`JHS_ST_ACK]) else $error("ack missing");
    AST_ACK_DROP: assert property (command_word_i != `JHS_CMD_TRANSFER |=> !status_word_o[`JHS_ST_ACK])
        else $error("ack stuck");
    AST_MOTOR_ON: assert property (s_take(`JHS_SEL_MOTOR_ON) |=> motor_enable_o && fault_code_word_o == 16'h0000)
        else $error("motor not on");
    AST_MOTOR_BIT: assert property (status_word_o[`JHS_ST_MOTOR] == motor_enable_o) else $error("motor bit");
    AST_HOME_OUT: assert property (s_home(`JHS_SEL_HOME_OUT) |=> drive_run_o && drive_outward_o && motor_enable_o
        && drive_speed_o == `JHS_LOW_SPEED) else $error("outward homing start");
    AST_HOME_IN: assert property (s_home(`JHS_SEL_HOME_IN) |=> drive_run_o && !drive_outward_o && motor_enable_o
        && drive_speed_o == `JHS_LOW_SPEED) else $error("inward homing start");
    AST_EXT_OUT: assert property (s_home(`JHS_SEL_EXT_OUT) |=> drive_run_o && drive_outward_o
        && drive_speed_o == $past(travel_speed_percent_i)) else $error("outer stop homing start");
    AST_EXT_IN: assert property (s_home(`JHS_SEL_EXT_IN) |=> drive_run_o && !drive_outward_o
        && drive_speed_o == $past(travel_speed_percent_i)) else $error("inner stop homing start");
    AST_GRIP: assert property (s_take(`JHS_SEL_HOME_OUT) ##0 gripped_i |=> !drive_run_o && status_word_o[`JHS_ST_ERROR]
        && fault_code_word_o == `JHS_FAULT_GRIPPED) else $error("gripped homing not refused");
    AST_REF_DONE: assert property ($fell(drive_run_o) |-> status_word_o[`JHS_ST_REFERENCED]
        && status_word_o[`JHS_ST_COMPLETE] && drive_speed_o == 8'h00) else $error("run end");
    AST_RUN_HOLD: assert property (drive_run_o && $past(drive_run_o) |-> $stable(drive_outward_o)
        && !status_word_o[`JHS_ST_REFERENCED]) else $error("run state");
endmodule // jhs_seq_properties
bind jhs_sequencer jhs_seq_properties i_jhs_seq_properties (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .operating_selector_i(operating_selector_i), .command_word_i(command_word_i),
    .travel_speed_percent_i(travel_speed_percent_i), .gripped_i(gripped_i), .motor_enable_o(motor_enable_o),
    .drive_run_o(drive_run_o), .drive_outward_o(drive_outward_o), .drive_speed_o(drive_speed_o),
    .status_word_o(status_word_o), .fault_code_word_o(fault_code_word_o));

// ==== tb/jhs_mech_model.sv ====
// jaw mechanics: raw position follows the drive until an end stop blocks it
`timescale 1ns/100ps
module jhs_mech_model #(parameter [15:0] LO = 16'h0100, parameter [15:0] HI = 16'h0180) (
    // clock and drive
    input wire clk_sys_i, input wire motor_enable_i, input wire run_i, input wire outward_i,
    input wire [7:0] speed_i,
    // measuring system
    output logic [15:0] raw_position_o
);
    initial raw_position_o = 16'h0140;
    // blocked jaws stop changing the position, which the design reads as resistance
    always @(posedge clk_sys_i) begin
        if (motor_enable_i && run_i && speed_i != 8'h00) begin
            if (outward_i && raw_position_o > LO)
                raw_position_o <= raw_position_o - 16'h0001;
            else if (!outward_i && raw_position_o < HI)
                raw_position_o <= raw_position_o + 16'h0001;
        end
    end
endmodule // jhs_mech_model

// ==== tb/jhs_sequencer_tb.sv ====
// self-checking testbench of the jaw homing sequencer
`timescale 1ns/100ps
`include "jhs_regs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t: got %h want %h", $time, a, b); end end
module jhs_sequencer_tb;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg gripped = 1'b0;
    reg [7:0] sel = 8'h00, recipe = 8'h00, speed = 8'h00;
    reg [15:0] cmd = 16'h0000, tol = 16'h0000, outer = 16'h0000, inner = 16'h0000;
    wire [15:0] raw, status, fault, pos, tol_q;
    wire [7:0] dspeed, recipe_q;
    wire men, run, outw;
    integer bad_count = 0;
    integer checked = 0;
    initial forever #2 clk = ~clk;
    jhs_sequencer i_jhs_sequencer (.clk_sys_i(clk), .resetn_i(resetn), .operating_selector_i(sel),
        .command_word_i(cmd), .recipe_index_i(recipe), .window_tolerance_i(tol), .travel_speed_percent_i(speed),
        .outer_target_i(outer), .inner_target_i(inner), .gripped_i(gripped), .raw_position_i(raw),
        .motor_enable_o(men), .drive_run_o(run), .drive_outward_o(outw), .drive_speed_o(dspeed),
        .status_word_o(status), .fault_code_word_o(fault), .measured_jaw_position_o(pos),
        .recipe_index_o(recipe_q), .window_tolerance_o(tol_q));
    jhs_mech_model i_jhs_mech_model (.clk_sys_i(clk), .motor_enable_i(men), .run_i(run), .outward_i(outw),
        .speed_i(dspeed), .raw_position_o(raw));
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    // handshake transfer; returns just after the taking edge
    task xfer(input [7:0] s);
        begin
            @(posedge clk);
            sel <= s;
            cmd <= `JHS_CMD_TRANSFER;
            @(posedge clk);
            #1;
            `CHK(status[`JHS_ST_ACK], 1'b1)
        end
    endtask
    task drop;
        begin
            @(posedge clk);
            cmd <= `JHS_CMD_IDLE;
            repeat (2) @(posedge clk);
            #1;
            `CHK(status[`JHS_ST_ACK], 1'b0)
        end
    endtask
    task home(input [7:0] s, input [15:0] want, input motor_after);
        integer n;
        begin
            xfer(s);
            `CHK(run, 1'b1)
            `CHK(men, 1'b1)
            `CHK(status[`JHS_ST_REFERENCED], 1'b0)
            `CHK(status[`JHS_ST_MOTION], 1'b1)
            drop();
            n = 0;
            while (run === 1'b1 && n < 2000) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            // a run that never stalls counts as a mismatch
            `CHK(n < 2000, 1'b1)
            repeat (4) @(posedge clk);
            #1;
            `CHK(dspeed, `JHS_SPEED_ZERO)
            `CHK(status[`JHS_ST_MOTION], 1'b0)
            `CHK(pos, want)
            `CHK(status[`JHS_ST_REFERENCED], 1'b1)
            `CHK(men, motor_after)
            `CHK(status[`JHS_ST_MOTOR], motor_after)
        end
    endtask
    task grip_refuse;
        begin
            @(posedge clk);
            gripped <= 1'b1;
            xfer(`JHS_SEL_HOME_OUT);
            `CHK(run, 1'b0)
            `CHK(fault, `JHS_FAULT_GRIPPED)
            `CHK(status[`JHS_ST_ERROR], 1'b1)
            drop();
        end
    endtask
    task motor_on;
        begin
            @(posedge clk);
            gripped <= 1'b0;
            xfer(`JHS_SEL_MOTOR_ON);
            `CHK(men, 1'b1)
            `CHK(status[`JHS_ST_MOTOR], 1'b1)
            `CHK(fault, `JHS_FAULT_NONE)
            drop();
        end
    endtask
    // outer 100 and inner 4000 stay within the controller limits
    task ext_home(input [7:0] s, input [15:0] want, input [7:0] spd);
        begin
            @(posedge clk);
            recipe <= 8'h05;
            tol <= 16'h0032;
            speed <= spd;
            outer <= 16'h0064;
            inner <= 16'h0FA0;
            home(s, want, 1'b0);
            `CHK(recipe_q, 8'h05)
            `CHK(tol_q, 16'h0032)
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        #1;
        `CHK(status, 16'h0000)
        home(`JHS_SEL_HOME_OUT, `JHS_POS_ZERO, 1'b1);
        home(`JHS_SEL_HOME_IN, `JHS_MAX_STROKE, 1'b1);
        grip_refuse();
        motor_on();
        ext_home(`JHS_SEL_EXT_OUT, 16'h0064, 8'h0A);
        motor_on();
        ext_home(`JHS_SEL_EXT_IN, 16'h0FA0, 8'h14);
        motor_on();
        tally_and_finish();
    end
    initial begin
        #40000;
        bad_count++;
        $display("[ERR] %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule // jhs_sequencer_tb
